// ### hw/cbs_defs.svh
// constants of the bus-cycle sequencer
// assumes one bus cycle per ref_clk_i period
`ifndef CBS_DEFS_SVH
`define CBS_DEFS_SVH

// dummy-cycle address
`define CBS_DUMMY_ADDR 16'hffff
// first opcode address after reset
`define CBS_RESET_PC   16'h0000
// page-select prefix bytes
`define CBS_PFX_18     8'h18
`define CBS_PFX_1A     8'h1a
// second opcode bytes after a prefix
`define CBS_OP_LDY_EXT 8'hfe
`define CBS_OP_STY_EXT 8'hff
`define CBS_OP_CPY_EXT 8'hbc
`define CBS_OP_CPD_EXT 8'hb3
// read/write line levels
`define CBS_RW_READ    1'b1
`define CBS_RW_WRITE   1'b0

`endif

// ### hw/cbs_pkg.sv
// types of the bus-cycle sequencer
// assumes cbs_defs.svh supplies the numeric constants
package cbs_pkg;

  // bus cycle step
  typedef enum logic [3:0] {
    ST_OPC, ST_AH, ST_AL, ST_OFS, ST_IDUM,
    ST_RD, ST_TD1, ST_TD2, ST_WR,
    ST_RDH, ST_RDL, ST_WRH, ST_WRL,
    ST_JTGT, ST_PSHL, ST_PSHH
  } cbs_step_t;

  // instruction cycle pattern
  typedef enum logic [3:0] {
    CL_NONE, CL_JMP, CL_RD8, CL_WR8, CL_RD16, CL_WR16,
    CL_RMW, CL_TST, CL_ARITH16, CL_JSR
  } cbs_class_t;

  // page-select prefix seen
  typedef enum logic [1:0] {
    PG_NONE, PG_18, PG_1A
  } cbs_page_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        rw;
    logic [7:0]  wdata;
  } cbs_bus_t;

  typedef struct packed {
    logic       ok;
    logic       ix;
    cbs_class_t cls;
  } cbs_dec_t;

  typedef struct packed {
    cbs_step_t   step;
    cbs_page_t   pg;
    cbs_dec_t    dec;
    logic [7:0]  opc;
    logic [15:0] pc;
    logic [15:0] ea;
    logic [7:0]  off;
    logic [15:0] rdat;
    cbs_bus_t    bus;
    logic        done;
    logic        unsup;
  } cbs_state_t;

endpackage

// ### hw/cbs_sequencer.sv
// bus-cycle sequencer: extended and x-indexed instruction cycles
// assumes memory answers reads within the same bus cycle and the core
// supplies register values and the read-modify-write result
`timescale 1ns/1ps
`include "cbs_defs.svh"

module cbs_sequencer (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  data_i,
  input  wire logic [7:0]  acc_a_i,
  input  wire logic [7:0]  acc_b_i,
  input  wire logic [15:0] d_acc_i,
  input  wire logic [15:0] x_idx_i,
  input  wire logic [15:0] y_idx_i,
  input  wire logic [15:0] sp_i,
  input  wire logic [7:0]  alu_result_i,
  output logic [15:0]      addr_o,
  output logic             rw_o,
  output logic [7:0]       data_o,
  output logic             instr_done_o,
  output logic             unsupported_o,
  output logic [7:0]       opcode_o,
  output logic [15:0]      load_data_o
);

  cbs_pkg::cbs_state_t st_ff;
  cbs_pkg::cbs_state_t nxt_st;

  // ****************************************
  // opcode decode
  // ****************************************
  function automatic cbs_pkg::cbs_dec_t decode(
    input cbs_pkg::cbs_page_t pg,
    input logic [7:0]         op
  );
    cbs_pkg::cbs_dec_t d;
    logic [3:0]        hi;
    logic [3:0]        lo;
    hi     = op[7:4];
    lo     = op[3:0];
    d.ok   = 1'b1;
    d.ix   = 1'b0;
    d.cls  = cbs_pkg::CL_NONE;
    if (pg == cbs_pkg::PG_18)
    begin
      case (op)
        `CBS_OP_LDY_EXT: d.cls = cbs_pkg::CL_RD16;
        `CBS_OP_STY_EXT: d.cls = cbs_pkg::CL_WR16;
        `CBS_OP_CPY_EXT: d.cls = cbs_pkg::CL_ARITH16;
        default:         d.ok  = 1'b0;
      endcase
    end
    else if (pg == cbs_pkg::PG_1A)
    begin
      if (op == `CBS_OP_CPD_EXT)
        d.cls = cbs_pkg::CL_ARITH16;
      else
        d.ok = 1'b0;
    end
    else
    begin
      case (hi)
        4'h6, 4'h7:
        begin
          d.ix = (hi == 4'h6);
          case (lo)
            4'hd: d.cls = cbs_pkg::CL_TST;
            4'he: d.cls = cbs_pkg::CL_JMP;
            4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hc,
            4'hf: d.cls = cbs_pkg::CL_RMW;
            default: d.ok = 1'b0;
          endcase
          if (!d.ix && lo == 4'he)
            d.ok = 1'b0;
        end
        4'hb, 4'hf:
        begin
          case (lo)
            4'h3: d.cls = cbs_pkg::CL_ARITH16;
            4'hc:
            begin
              d.cls = cbs_pkg::CL_ARITH16;
              d.ok  = (hi == 4'hb);
            end
            4'hd: d.cls = (hi == 4'hb) ? cbs_pkg::CL_JSR
                                       : cbs_pkg::CL_WR16;
            4'hf: d.cls = cbs_pkg::CL_WR16;
            default: d.ok = 1'b0;
          endcase
        end
        4'ha, 4'he:
        begin
          d.ix = 1'b1;
          case (lo)
            4'h7: d.cls = cbs_pkg::CL_WR8;
            4'hc:
            begin
              d.cls = cbs_pkg::CL_RD16;
              d.ok  = (hi == 4'he);
            end
            4'he: d.cls = cbs_pkg::CL_RD16;
            4'h3, 4'hd, 4'hf: d.ok = 1'b0;
            default: d.cls = cbs_pkg::CL_RD8;
          endcase
        end
        default: d.ok = 1'b0;
      endcase
    end
    return d;
  endfunction

  // ****************************************
  // store data selection
  // ****************************************
  function automatic logic [15:0] store_word(
    input cbs_pkg::cbs_page_t pg,
    input logic [7:0]         op,
    input logic [7:0]         a,
    input logic [7:0]         b,
    input logic [15:0]        d,
    input logic [15:0]        x,
    input logic [15:0]        y,
    input logic [15:0]        sp
  );
    logic [15:0] w;
    w = 16'h0000;
    if (pg == cbs_pkg::PG_18)
      w = y;
    else if (op[3:0] == 4'h7)
      w = op[6] ? {8'h00, b} : {8'h00, a};
    else if (op[3:0] == 4'hd)
      w = d;
    else
      w = op[6] ? x : sp;
    return w;
  endfunction

  // ****************************************
  // next cycle
  // ****************************************
  always_comb
  begin
    logic [15:0] sw;
    logic        go;
    logic        fin;
    cbs_pkg::cbs_dec_t dd;
    sw     = store_word(st_ff.pg, st_ff.opc, acc_a_i, acc_b_i, d_acc_i,
                        x_idx_i, y_idx_i, sp_i);
    go     = 1'b0;
    fin    = 1'b0;
    dd     = decode(st_ff.pg, data_i);
    nxt_st = st_ff;
    nxt_st.done  = 1'b0;
    nxt_st.unsup = 1'b0;
    nxt_st.bus.rw    = `CBS_RW_READ;
    nxt_st.bus.wdata = 8'h00;
    nxt_st.bus.addr  = `CBS_DUMMY_ADDR;
    case (st_ff.step)
      cbs_pkg::ST_OPC:
      begin
        nxt_st.pc       = st_ff.pc + 16'h0001;
        nxt_st.bus.addr = nxt_st.pc;
        if (st_ff.pg == cbs_pkg::PG_NONE && data_i == `CBS_PFX_18)
          nxt_st.pg = cbs_pkg::PG_18;
        else if (st_ff.pg == cbs_pkg::PG_NONE && data_i == `CBS_PFX_1A)
          nxt_st.pg = cbs_pkg::PG_1A;
        else
        begin
          nxt_st.opc = data_i;
          nxt_st.dec = dd;
          if (!dd.ok)
          begin
            nxt_st.unsup = 1'b1;
            fin          = 1'b1;
          end
          else if (dd.ix)
            nxt_st.step = cbs_pkg::ST_OFS;
          else
            nxt_st.step = cbs_pkg::ST_AH;
        end
      end
      cbs_pkg::ST_AH:
      begin
        nxt_st.ea[15:8] = data_i;
        nxt_st.pc       = st_ff.pc + 16'h0001;
        nxt_st.bus.addr = nxt_st.pc;
        nxt_st.step     = cbs_pkg::ST_AL;
      end
      cbs_pkg::ST_AL:
      begin
        nxt_st.ea[7:0] = data_i;
        nxt_st.pc      = st_ff.pc + 16'h0001;
        go             = 1'b1;
      end
      cbs_pkg::ST_OFS:
      begin
        nxt_st.off  = data_i;
        nxt_st.pc   = st_ff.pc + 16'h0001;
        nxt_st.step = cbs_pkg::ST_IDUM;
      end
      cbs_pkg::ST_IDUM:
      begin
        nxt_st.ea = x_idx_i + {8'h00, st_ff.off};
        go        = 1'b1;
      end
      cbs_pkg::ST_RD:
      begin
        nxt_st.rdat = {8'h00, data_i};
        if (st_ff.dec.cls == cbs_pkg::CL_RMW ||
            st_ff.dec.cls == cbs_pkg::CL_TST)
          nxt_st.step = cbs_pkg::ST_TD1;
        else
          fin = 1'b1;
      end
      cbs_pkg::ST_TD1:
      begin
        if (st_ff.dec.cls == cbs_pkg::CL_RMW)
        begin
          nxt_st.step      = cbs_pkg::ST_WR;
          nxt_st.bus.addr  = st_ff.ea;
          nxt_st.bus.rw    = `CBS_RW_WRITE;
          nxt_st.bus.wdata = alu_result_i;
        end
        else
          nxt_st.step = cbs_pkg::ST_TD2;
      end
      cbs_pkg::ST_TD2,
      cbs_pkg::ST_WR,
      cbs_pkg::ST_WRL:
        fin = 1'b1;
      cbs_pkg::ST_RDH:
      begin
        nxt_st.rdat[15:8] = data_i;
        nxt_st.step       = cbs_pkg::ST_RDL;
        nxt_st.bus.addr   = st_ff.ea + 16'h0001;
      end
      cbs_pkg::ST_RDL:
      begin
        nxt_st.rdat[7:0] = data_i;
        if (st_ff.dec.cls == cbs_pkg::CL_ARITH16)
          nxt_st.step = cbs_pkg::ST_TD2;
        else
          fin = 1'b1;
      end
      // low byte at address plus one
      cbs_pkg::ST_WRH:
      begin
        nxt_st.step      = cbs_pkg::ST_WRL;
        nxt_st.bus.addr  = st_ff.ea + 16'h0001;
        nxt_st.bus.rw    = `CBS_RW_WRITE;
        nxt_st.bus.wdata = sw[7:0];
      end
      cbs_pkg::ST_JTGT:
      begin
        nxt_st.step      = cbs_pkg::ST_PSHL;
        nxt_st.bus.addr  = sp_i;
        nxt_st.bus.rw    = `CBS_RW_WRITE;
        nxt_st.bus.wdata = st_ff.pc[7:0];
      end
      cbs_pkg::ST_PSHL:
      begin
        nxt_st.step      = cbs_pkg::ST_PSHH;
        nxt_st.bus.addr  = sp_i - 16'h0001;
        nxt_st.bus.rw    = `CBS_RW_WRITE;
        nxt_st.bus.wdata = st_ff.pc[15:8];
      end
      cbs_pkg::ST_PSHH:
      begin
        nxt_st.pc = st_ff.ea;
        fin       = 1'b1;
      end
      default:
        fin = 1'b1;
    endcase

    // first access after the operand address is known
    if (go)
    begin
      nxt_st.bus.addr = nxt_st.ea;
      case (st_ff.dec.cls)
        cbs_pkg::CL_JMP:
        begin
          nxt_st.pc = nxt_st.ea;
          fin       = 1'b1;
        end
        cbs_pkg::CL_WR8:
        begin
          nxt_st.step      = cbs_pkg::ST_WR;
          nxt_st.bus.rw    = `CBS_RW_WRITE;
          nxt_st.bus.wdata = sw[7:0];
        end
        cbs_pkg::CL_WR16:
        begin
          nxt_st.step      = cbs_pkg::ST_WRH;
          nxt_st.bus.rw    = `CBS_RW_WRITE;
          nxt_st.bus.wdata = sw[15:8];
        end
        cbs_pkg::CL_RD16,
        cbs_pkg::CL_ARITH16:
          nxt_st.step = cbs_pkg::ST_RDH;
        cbs_pkg::CL_JSR:
          nxt_st.step = cbs_pkg::ST_JTGT;
        default:
          nxt_st.step = cbs_pkg::ST_RD;
      endcase
    end

    // instruction end: fetch next opcode
    if (fin)
    begin
      nxt_st.done      = 1'b1;
      nxt_st.step      = cbs_pkg::ST_OPC;
      nxt_st.pg        = cbs_pkg::PG_NONE;
      nxt_st.bus.addr  = nxt_st.pc;
      nxt_st.bus.rw    = `CBS_RW_READ;
      nxt_st.bus.wdata = 8'h00;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_ff           <= '0;
      st_ff.step      <= cbs_pkg::ST_OPC;
      st_ff.pg        <= cbs_pkg::PG_NONE;
      st_ff.pc        <= `CBS_RESET_PC;
      st_ff.bus.addr  <= `CBS_RESET_PC;
      st_ff.bus.rw    <= `CBS_RW_READ;
    end
    else
      st_ff <= nxt_st;
  end

  assign addr_o        = st_ff.bus.addr;
  assign rw_o          = st_ff.bus.rw;
  assign data_o        = st_ff.bus.wdata;
  assign instr_done_o  = st_ff.done;
  assign unsupported_o = st_ff.unsup;
  assign opcode_o      = st_ff.opc;
  assign load_data_o   = st_ff.rdat;

endmodule

// ### sim/cbs_mem_model.sv
// memory on the far side of the sequencer bus
// assumes one bus cycle per clock
`timescale 1ns/1ps
module cbs_mem_model (
  input  wire logic        ref_clk_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        rw_i,
  input  wire logic [7:0]  wdata_i,
  output logic [7:0]       rdata_o
);
  logic [7:0] mem [65536];

  initial
    for (int i = 0; i < 65536; i++)
      mem[i] = i[7:0] ^ i[15:8] ^ 8'h3c;

  assign rdata_o = rw_i ? mem[addr_i] : ~mem[addr_i];

  always @(posedge ref_clk_i)
    if (!rw_i)
      mem[addr_i] <= wdata_i;
endmodule

// ### sim/cbs_seq_properties.sv
// checker of the bus-cycle sequencer ports
// assumes it is bound into cbs_sequencer
`timescale 1ns/1ps
module cbs_seq_properties (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  data_i,
  input wire logic [15:0] x_idx_i,
  input wire logic [15:0] sp_i,
  input wire logic [7:0]  alu_result_i,
  input wire logic [15:0] addr_o,
  input wire logic        rw_o,
  input wire logic [7:0]  data_o,
  input wire logic        instr_done_o,
  input wire logic        unsupported_o
);
  // ****************
  // bus properties
  // ****************
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_RD_DATA_ZERO: assert property (rw_o |-> data_o == 8'h00)
    else $error("data driven on a read cycle");
  AST_WRITE_RUN: assert property (!rw_o && $past(!rw_o) |=> rw_o)
    else $error("more than two writes in a row");
  AST_WRITE_PAIR: assert property (
    !rw_o && !$past(rw_o) |->
    addr_o == $past(addr_o) + 16'h1 || addr_o == $past(addr_o) - 16'h1)
    else $error("paired write not at a neighbouring address");
  AST_RMW_DATA: assert property (
    !rw_o && $past(addr_o) == 16'hffff && $past(addr_o, 2) == addr_o
    |-> data_o == $past(alu_result_i))
    else $error("write-back data is not the modify result");
  AST_PUSH_ORDER: assert property (
    !rw_o && !$past(rw_o) && addr_o == $past(addr_o) - 16'h1
    |-> addr_o == $past(sp_i) - 16'h1
    && {data_o, $past(data_o)} == $past(addr_o, 3) + 16'h1)
    else $error("return address push wrong");
  AST_CALL_TARGET: assert property (
    !rw_o && !$past(rw_o) && addr_o == $past(addr_o) - 16'h1
    |=> instr_done_o && addr_o == $past(addr_o, 3))
    else $error("call does not continue at its target");
  AST_EXT_ADDR: assert property (
    $fell(rw_o) && $past(addr_o) != 16'hffff
    && $past(addr_o) == $past(addr_o, 2) + 16'h1
    |-> addr_o == {$past(data_i, 2), $past(data_i)})
    else $error("extended address not high byte first");
  AST_IX_ADDR: assert property (
    $past(addr_o) == 16'hffff && $past(instr_done_o, 3) && $past(rw_o, 2)
    && $past(addr_o, 2) == $past(addr_o, 3) + 16'h1
    |-> addr_o == $past(x_idx_i) + {8'h00, $past(data_i, 2)})
    else $error("indexed address not x plus offset");

  cover property (!rw_o && !$past(rw_o));
  cover property (!rw_o && $past(addr_o) == 16'hffff);
  cover property (unsupported_o);
endmodule

bind cbs_sequencer cbs_seq_properties u_props (.ref_clk_i, .rst_n_i,
  .data_i, .x_idx_i, .sp_i, .alu_result_i, .addr_o, .rw_o, .data_o,
  .instr_done_o, .unsupported_o);

// ### sim/tb.sv
// testbench of the bus-cycle sequencer
// assumes cbs_mem_model answers the bus
`timescale 1ns/1ps
module tb;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  rdata, wdata, acc_a = 8'h00, acc_b = 8'h00, alu = 8'h00;
  logic [7:0]  opc;
  logic [15:0] d_acc = 16'h0, x_idx = 16'h0, y_idx = 16'h0, sp = 16'h0;
  logic [15:0] addr, load_data, ld_exp, pc = 16'h0000;
  logic        rw, done, unsup, first = 1'b1, pend_u = 1'b0;
  logic [31:0] seed = 32'd12361, r;
  logic [26:0] q[$];
  logic [3:0]  mo[10] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha,
                         4'hc, 4'hf};
  int          num_errors = 0, checked = 0;

  always #12.5 ref_clk = ~ref_clk;

  cbs_sequencer dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .data_i(rdata),
    .acc_a_i(acc_a), .acc_b_i(acc_b), .d_acc_i(d_acc), .x_idx_i(x_idx),
    .y_idx_i(y_idx), .sp_i(sp), .alu_result_i(alu), .addr_o(addr),
    .rw_o(rw), .data_o(wdata), .instr_done_o(done), .unsupported_o(unsup),
    .opcode_o(opc), .load_data_o(load_data));
  cbs_mem_model u_mem (.ref_clk_i(ref_clk), .addr_i(addr), .rw_i(rw),
    .wdata_i(wdata), .rdata_o(rdata));

  // ****************
  // model tasks
  // ****************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] roff();
    logic [31:0] v;
    v = rnd();
    return {9'h000, v[6:0]};
  endfunction

  task automatic chk(input string nm, input logic [26:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d);
    q.push_back({2'b00, a, !w, w ? d : 8'h00});
  endtask

  task automatic rd(input logic [15:0] a, input logic lo);
    cyc(a, 1'b0, 8'h00);
    ld_exp = {lo ? ld_exp[7:0] : 8'h00, u_mem.mem[a]};
  endtask

  task automatic put(input logic [7:0] b, input logic f);
    u_mem.mem[pc] = b;
    q.push_back({f && !first, f && pend_u, pc, 1'b1, 8'h00});
    first = first && !f;
    pend_u = pend_u && !f;
    pc = pc + 16'h1;
  endtask

  task automatic ins(input logic [7:0] pf, op, input cbs_pkg::cbs_class_t c,
                     input logic ix, input logic [15:0] v);
    logic [15:0] ea;
    logic [15:0] w;
    if (pf != 8'h00)
      put(pf, 1'b1);
    put(op, pf == 8'h00);
    if (c == cbs_pkg::CL_NONE)
    begin
      pend_u = 1'b1;
      return;
    end
    ea = ix ? x_idx + {8'h00, v[7:0]} : v;
    if (!ix)
      put(v[15:8], 1'b0);
    put(v[7:0], 1'b0);
    if (ix)
      cyc(16'hffff, 1'b0, 8'h00);
    w = op == 8'hbf ? sp : op == 8'hff ? (pf != 8'h00 ? y_idx : x_idx) : d_acc;
    case (c)
      cbs_pkg::CL_RD8: rd(ea, 1'b0);
      cbs_pkg::CL_WR8: cyc(ea, 1'b1, op == 8'he7 ? acc_b : acc_a);
      cbs_pkg::CL_RD16:
      begin
        rd(ea, 1'b0);
        rd(ea + 16'h1, 1'b1);
      end
      cbs_pkg::CL_WR16:
      begin
        cyc(ea, 1'b1, w[15:8]);
        cyc(ea + 16'h1, 1'b1, w[7:0]);
      end
      cbs_pkg::CL_RMW:
      begin
        rd(ea, 1'b0);
        cyc(16'hffff, 1'b0, 8'h00);
        cyc(ea, 1'b1, alu);
      end
      cbs_pkg::CL_TST:
      begin
        rd(ea, 1'b0);
        cyc(16'hffff, 1'b0, 8'h00);
        cyc(16'hffff, 1'b0, 8'h00);
      end
      cbs_pkg::CL_ARITH16:
      begin
        rd(ea, 1'b0);
        rd(ea + 16'h1, 1'b1);
        cyc(16'hffff, 1'b0, 8'h00);
      end
      cbs_pkg::CL_JSR:
      begin
        cyc(ea, 1'b0, 8'h00);
        cyc(sp, 1'b1, pc[7:0]);
        cyc(sp - 16'h1, 1'b1, pc[15:8]);
        pc = ea;
      end
      default: pc = ea;
    endcase
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************
  // main sequence
  // ****************
  initial
  begin
    @(negedge ref_clk);
    r = rnd();
    {alu, acc_b, acc_a} = r[23:0];
    r = rnd();
    {y_idx, d_acc} = r;
    r = rnd();
    x_idx = {4'h9, r[11:0]};
    sp = {4'hc, r[27:16]};
    ins(8'h00, 8'hfd, cbs_pkg::CL_WR16, 1'b0, 16'h8000);
    ins(8'h00, 8'hbf, cbs_pkg::CL_WR16, 1'b0, 16'h8010);
    ins(8'h00, 8'hff, cbs_pkg::CL_WR16, 1'b0, 16'h8020);
    ins(8'h18, 8'hfe, cbs_pkg::CL_RD16, 1'b0, 16'h8030);
    ins(8'h18, 8'hff, cbs_pkg::CL_WR16, 1'b0, 16'h8040);
    for (int i = 0; i < 10; i++)
      ins(8'h00, {4'h7, mo[i]}, cbs_pkg::CL_RMW, 1'b0, 16'h8100 + i * 16);
    ins(8'h00, 8'h7d, cbs_pkg::CL_TST, 1'b0, 16'h8200);
    ins(8'h00, 8'hb3, cbs_pkg::CL_ARITH16, 1'b0, 16'h8210);
    ins(8'h00, 8'hf3, cbs_pkg::CL_ARITH16, 1'b0, 16'h8220);
    ins(8'h00, 8'hbc, cbs_pkg::CL_ARITH16, 1'b0, 16'h8230);
    ins(8'h1a, 8'hb3, cbs_pkg::CL_ARITH16, 1'b0, 16'h8240);
    ins(8'h18, 8'hbc, cbs_pkg::CL_ARITH16, 1'b0, 16'h8250);
    ins(8'h00, 8'h01, cbs_pkg::CL_NONE, 1'b0, 16'h0);
    ins(8'h00, 8'hbd, cbs_pkg::CL_JSR, 1'b0, 16'h5000);
    for (int h = 0; h < 2; h++)
      for (int l = 0; l < 12; l++)
        if (l != 3)
          ins(8'h00, {h ? 4'he : 4'ha, l[3:0]},
              l == 7 ? cbs_pkg::CL_WR8 : cbs_pkg::CL_RD8, 1'b1, roff());
    for (int i = 0; i < 10; i++)
      ins(8'h00, {4'h6, mo[i]}, cbs_pkg::CL_RMW, 1'b1, roff());
    ins(8'h00, 8'h6d, cbs_pkg::CL_TST, 1'b1, roff());
    ins(8'h00, 8'hec, cbs_pkg::CL_RD16, 1'b1, 16'h00f0);
    ins(8'h00, 8'hae, cbs_pkg::CL_RD16, 1'b1, 16'h00f0);
    ins(8'h00, 8'hee, cbs_pkg::CL_RD16, 1'b1, 16'h00f0);
    ins(8'h00, 8'h6e, cbs_pkg::CL_JMP, 1'b1, 16'h00ff);
    ins(8'h00, 8'h01, cbs_pkg::CL_NONE, 1'b0, 16'h0);
    ins(8'h00, 8'h01, cbs_pkg::CL_NONE, 1'b0, 16'h0);
    repeat (7) @(negedge ref_clk);
    rst_n = 1'b1;
    while (q.size() > 0)
    begin
      chk("bus", {done, unsup, addr, rw, wdata}, q.pop_front());
      if (q.size() == 0)
        chk("load", {11'h000, load_data}, {11'h000, ld_exp});
      if (q.size() == 0)
        chk("opcode", {19'h00000, opc}, {19'h00000, 8'h01});
      @(negedge ref_clk);
    end
    stop_test();
  end

  initial
  begin
    #(25 * 3000);
    num_errors++;
    stop_test();
  end
endmodule
